// >>> i2cmx_consts.svh
// Purpose: Shared offsets, field positions, reset values and timing counts
// Assumes: clk_sys at 10 MHz on both ends
// Notes: Included by bare name; definitions only
`ifndef I2CMX_CONSTS_SVH
`define I2CMX_CONSTS_SVH

// ----------------------------------------------------------------------
// Device address and control byte layout
// ----------------------------------------------------------------------
`define I2CMX_ADDR_UPPER 4'hB
`define I2CMX_CTRL_RESET 3'h0
`define I2CMX_ENABLE_BIT 2
`define I2CMX_SPARE_BIT 3
`define I2CMX_FLAG_LSB 4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define I2CMX_CLK_HZ 10_000_000
`define I2CMX_SCL_HZ 100_000
`define I2CMX_QUARTER_CYC (`I2CMX_CLK_HZ / (4 * `I2CMX_SCL_HZ))

// ----------------------------------------------------------------------
// Controller register map
// ----------------------------------------------------------------------
`define I2CMX_REG_CMD 32'h0000_0000
`define I2CMX_REG_STATUS 32'h0000_0004
`define I2CMX_RESP_OKAY 2'h0
`define I2CMX_RESP_SLVERR 2'h2

`endif

// >>> i2cmx_pkg.sv
// Purpose: Types shared by both ends of the selector link
// Assumes: Nothing beyond the consts header
// Notes: No constants here; those live in i2cmx_consts.svh
package i2cmx_pkg;

   typedef enum logic [2:0] {
      DEV_IDLE,
      DEV_ADDR,
      DEV_ADDR_ACK,
      DEV_WRITE,
      DEV_WRITE_ACK,
      DEV_READ,
      DEV_READ_ACK
   } i2cmx_dev_state_t;

   typedef enum logic [1:0] {
      HST_IDLE,
      HST_START,
      HST_BIT,
      HST_STOP
   } i2cmx_host_state_t;

endpackage : i2cmx_pkg

// >>> i2cmx_link_if.sv
// Purpose: Two-wire link plus combined interrupt between controller and selector
// Assumes: Open-drain wires with pull-ups; enables active low
// Notes: Wire levels resolved here from drivers and enables
`timescale 1ns/1ps
`default_nettype none

interface i2cmx_link_if;
   logic hostSclOut;
   logic hostSclOeN;
   logic hostSdaOut;
   logic hostSdaOeN;
   logic devSdaOut;
   logic devSdaOeN;
   logic devIrqOut;
   logic devIrqOeN;
   logic scl;
   logic sda;
   logic irqLine;

   // ----------------------------------------------------------------------
   // Wired-AND resolution
   // ----------------------------------------------------------------------
   assign scl = hostSclOeN | hostSclOut;
   assign sda = (hostSdaOeN | hostSdaOut) & (devSdaOeN | devSdaOut);
   assign irqLine = devIrqOeN | devIrqOut;

   modport dev (
      input scl,
      input sda,
      output devSdaOut,
      output devSdaOeN,
      output devIrqOut,
      output devIrqOeN
   );

   modport host (
      input scl,
      input sda,
      input irqLine,
      output hostSclOut,
      output hostSclOeN,
      output hostSdaOut,
      output hostSdaOeN
   );
endinterface : i2cmx_link_if

`default_nettype wire

// >>> i2cmx_host_ctrl.sv
// Purpose: Two-wire bus controller for the selector, ordered over AXI4-Lite
// Assumes: One byte per transfer; SCL made here by a divider
// Notes: CMD write starts a transfer when idle; STATUS shows result
`timescale 1ns/1ps
`default_nettype none
`include "i2cmx_consts.svh"

module i2cmx_host_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link
   i2cmx_link_if.host link
);

   i2cmx_pkg::i2cmx_host_state_t state;
   logic [31:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic awGot;
   logic wGot;
   logic [6:0] cmdAddr;
   logic cmdRead;
   logic [7:0] cmdData;
   logic [7:0] rdData;
   logic nackFlag;
   logic busy;
   logic go;
   logic [4:0] divCnt;
   logic tick;
   logic [1:0] phase;
   logic byteIdx;
   logic [3:0] bitIdx;
   logic [1:0] inMeta;
   logic [1:0] inSync;

   function automatic logic pickBit(input logic [7:0] b, input logic [3:0] i);
      pickBit = (i == 4'h8) ? 1'b1 : b[3'(4'h7 - i)];
   endfunction : pickBit

   // ----------------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------------
   assign go = awGot && wGot && !s_axi_bvalid && (awAddr == `I2CMX_REG_CMD) && wStrb[0] && !busy;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `I2CMX_RESP_OKAY;
         awGot <= 1'b0;
         wGot <= 1'b0;
         awAddr <= 32'h0000_0000;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         cmdAddr <= 7'h00;
         cmdRead <= 1'b0;
         cmdData <= 8'h00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awAddr <= s_axi_awaddr;
            awGot <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            wGot <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (awGot && wGot && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr == `I2CMX_REG_CMD || awAddr == `I2CMX_REG_STATUS) ?
               `I2CMX_RESP_OKAY : `I2CMX_RESP_SLVERR;
            if (awAddr == `I2CMX_REG_CMD && !busy)
            begin
               if (wStrb[0])
               begin
                  cmdAddr <= wData[6:0];
                  cmdRead <= wData[7];
               end
               if (wStrb[1])
                  cmdData <= wData[15:8];
            end
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            awGot <= 1'b0;
            wGot <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `I2CMX_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `I2CMX_RESP_OKAY;
         if (s_axi_araddr == `I2CMX_REG_CMD)
            s_axi_rdata <= {16'h0000, cmdData, cmdRead, cmdAddr};
         else if (s_axi_araddr == `I2CMX_REG_STATUS)
            s_axi_rdata <= {16'h0000, rdData, 5'h00, !inSync[1], nackFlag, busy};
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `I2CMX_RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Quarter-bit divider and input sync
   // ----------------------------------------------------------------------
   assign tick = (divCnt == 5'(`I2CMX_QUARTER_CYC - 1));

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         divCnt <= 5'h00;
      else if (tick || state == i2cmx_pkg::HST_IDLE)
         divCnt <= 5'h00;
      else
         divCnt <= divCnt + 5'h01;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         inMeta <= 2'h3;
         inSync <= 2'h3;
      end
      else
      begin
         inMeta <= {link.irqLine, link.sda};
         inSync <= inMeta;
      end
   end

   // ----------------------------------------------------------------------
   // Bus sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= i2cmx_pkg::HST_IDLE;
         phase <= 2'h0;
         byteIdx <= 1'b0;
         bitIdx <= 4'h0;
         busy <= 1'b0;
         nackFlag <= 1'b0;
         rdData <= 8'h00;
         link.hostSclOut <= 1'b0;
         link.hostSdaOut <= 1'b0;
         link.hostSclOeN <= 1'b1;
         link.hostSdaOeN <= 1'b1;
      end
      else if (state == i2cmx_pkg::HST_IDLE)
      begin
         if (go)
         begin
            state <= i2cmx_pkg::HST_START;
            phase <= 2'h0;
            busy <= 1'b1;
            nackFlag <= 1'b0;
         end
      end
      else if (tick)
      begin
         phase <= phase + 2'h1;
         unique case (state)
            i2cmx_pkg::HST_START:
            begin
               if (phase == 2'h0)
                  link.hostSdaOeN <= 1'b0;
               if (phase == 2'h1)
                  link.hostSclOeN <= 1'b0;
               if (phase == 2'h3)
               begin
                  state <= i2cmx_pkg::HST_BIT;
                  byteIdx <= 1'b0;
                  bitIdx <= 4'h0;
               end
            end
            i2cmx_pkg::HST_BIT:
            begin
               if (phase == 2'h0)
                  link.hostSdaOeN <= byteIdx ? pickBit(cmdRead ? 8'hFF : cmdData, bitIdx)
                                             : pickBit({cmdAddr, cmdRead}, bitIdx);
               if (phase == 2'h1)
                  link.hostSclOeN <= 1'b1;
               if (phase == 2'h2)
               begin
                  if (bitIdx == 4'h8 && !(byteIdx && cmdRead) && inSync[0])
                     nackFlag <= 1'b1;
                  if (bitIdx != 4'h8 && byteIdx && cmdRead)
                     rdData <= {rdData[6:0], inSync[0]};
               end
               if (phase == 2'h3)
               begin
                  link.hostSclOeN <= 1'b0;
                  if (bitIdx != 4'h8)
                     bitIdx <= bitIdx + 4'h1;
                  else if (byteIdx || nackFlag)
                     state <= i2cmx_pkg::HST_STOP;
                  else
                  begin
                     byteIdx <= 1'b1;
                     bitIdx <= 4'h0;
                  end
               end
            end
            i2cmx_pkg::HST_STOP:
            begin
               if (phase == 2'h0)
                  link.hostSdaOeN <= 1'b0;
               if (phase == 2'h1)
                  link.hostSclOeN <= 1'b1;
               if (phase == 2'h2)
                  link.hostSdaOeN <= 1'b1;
               if (phase == 2'h3)
               begin
                  state <= i2cmx_pkg::HST_IDLE;
                  busy <= 1'b0;
               end
            end
         endcase
      end
   end

endmodule : i2cmx_host_ctrl

`default_nettype wire

// >>> i2cmx_mux_dev.sv
// Purpose: Control logic of a four-channel downstream bus selector
// Assumes: SCL slow against clk_sys; straps static; rstn is power-on reset
// Notes: Channel change applied at stop; flags sampled when read byte loads
`timescale 1ns/1ps
`default_nettype none
`include "i2cmx_consts.svh"

module i2cmx_mux_dev (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Upstream link
   i2cmx_link_if.dev link,
   // Address straps
   input wire logic [2:0] hwAddrPins,
   // Per-channel interrupt inputs
   input wire logic chan0IrqInN,
   input wire logic chan1IrqInN,
   input wire logic chan2IrqInN,
   input wire logic chan3IrqInN,
   // Downstream connection enables
   output logic [3:0] downstreamPairEn
);

   i2cmx_pkg::i2cmx_dev_state_t state;
   logic [8:0] inMeta;
   logic [8:0] inSync;
   logic sclPrev;
   logic sdaPrev;
   logic sclNow;
   logic sdaNow;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic [3:0] bitCnt;
   logic [7:0] shiftReg;
   logic rwBit;
   logic masterAck;
   logic [2:0] chanSel;
   logic [3:0] irqFlags;
   logic [7:0] txByte;
   logic addrMatch;
   logic writeDone;

   function automatic logic [3:0] chanDecode(input logic [2:0] sel);
      chanDecode = sel[`I2CMX_ENABLE_BIT] ? (4'h1 << sel[1:0]) : 4'h0;
   endfunction : chanDecode

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         inMeta <= 9'h1FF;
         inSync <= 9'h1FF;
      end
      else
      begin
         inMeta <= {link.scl, link.sda, hwAddrPins,
                    chan3IrqInN, chan2IrqInN, chan1IrqInN, chan0IrqInN};
         inSync <= inMeta;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end
      else
      begin
         sclPrev <= sclNow;
         sdaPrev <= sdaNow;
      end
   end

   assign sclNow = inSync[8];
   assign sdaNow = inSync[7];
   assign sclRise = sclNow && !sclPrev;
   assign sclFall = !sclNow && sclPrev;
   assign startSeen = sclNow && sclPrev && sdaPrev && !sdaNow;
   assign stopSeen = sclNow && sclPrev && !sdaPrev && sdaNow;
   assign irqFlags = ~inSync[3:0];
   assign txByte = {irqFlags, 1'b0, chanSel};
   assign addrMatch = (shiftReg[7:1] == {`I2CMX_ADDR_UPPER, inSync[6:4]});
   assign writeDone = (state == i2cmx_pkg::DEV_WRITE) && sclFall && (bitCnt == 4'h8);

   // ----------------------------------------------------------------------
   // Serial state machine
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= i2cmx_pkg::DEV_IDLE;
         bitCnt <= 4'h0;
         shiftReg <= 8'h00;
         rwBit <= 1'b0;
         masterAck <= 1'b0;
         link.devSdaOut <= 1'b0;
         link.devSdaOeN <= 1'b1;
      end
      else if (startSeen)
      begin
         state <= i2cmx_pkg::DEV_ADDR;
         bitCnt <= 4'h0;
         link.devSdaOeN <= 1'b1;
      end
      else if (stopSeen)
      begin
         state <= i2cmx_pkg::DEV_IDLE;
         link.devSdaOeN <= 1'b1;
      end
      else
      begin
         unique case (state)
            i2cmx_pkg::DEV_IDLE:
               link.devSdaOeN <= 1'b1;
            i2cmx_pkg::DEV_ADDR:
            begin
               if (sclRise)
               begin
                  shiftReg <= {shiftReg[6:0], sdaNow};
                  bitCnt <= bitCnt + 4'h1;
               end
               else if (sclFall && bitCnt == 4'h8)
               begin
                  if (addrMatch)
                  begin
                     rwBit <= shiftReg[0];
                     link.devSdaOeN <= 1'b0;
                     state <= i2cmx_pkg::DEV_ADDR_ACK;
                  end
                  else
                     state <= i2cmx_pkg::DEV_IDLE;
               end
            end
            i2cmx_pkg::DEV_ADDR_ACK:
            begin
               if (sclFall)
               begin
                  bitCnt <= 4'h0;
                  if (rwBit)
                  begin
                     shiftReg <= txByte;
                     link.devSdaOeN <= txByte[7];
                     state <= i2cmx_pkg::DEV_READ;
                  end
                  else
                  begin
                     link.devSdaOeN <= 1'b1;
                     state <= i2cmx_pkg::DEV_WRITE;
                  end
               end
            end
            i2cmx_pkg::DEV_WRITE:
            begin
               if (sclRise)
               begin
                  shiftReg <= {shiftReg[6:0], sdaNow};
                  bitCnt <= bitCnt + 4'h1;
               end
               else if (writeDone)
               begin
                  link.devSdaOeN <= 1'b0;
                  state <= i2cmx_pkg::DEV_WRITE_ACK;
               end
            end
            i2cmx_pkg::DEV_WRITE_ACK:
            begin
               if (sclFall)
               begin
                  link.devSdaOeN <= 1'b1;
                  bitCnt <= 4'h0;
                  state <= i2cmx_pkg::DEV_WRITE;
               end
            end
            i2cmx_pkg::DEV_READ:
            begin
               if (sclFall)
               begin
                  bitCnt <= bitCnt + 4'h1;
                  if (bitCnt == 4'h7)
                  begin
                     link.devSdaOeN <= 1'b1;
                     state <= i2cmx_pkg::DEV_READ_ACK;
                  end
                  else
                  begin
                     shiftReg <= {shiftReg[6:0], 1'b0};
                     link.devSdaOeN <= shiftReg[6];
                  end
               end
            end
            i2cmx_pkg::DEV_READ_ACK:
            begin
               if (sclRise)
                  masterAck <= !sdaNow;
               else if (sclFall)
               begin
                  if (masterAck)
                  begin
                     shiftReg <= txByte;
                     link.devSdaOeN <= txByte[7];
                     bitCnt <= 4'h0;
                     state <= i2cmx_pkg::DEV_READ;
                  end
                  else
                     state <= i2cmx_pkg::DEV_IDLE;
               end
            end
            default:
               state <= i2cmx_pkg::DEV_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control register and connection
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         chanSel <= `I2CMX_CTRL_RESET;
      else if (writeDone)
         chanSel <= shiftReg[2:0];
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         downstreamPairEn <= 4'h0;
      else if (stopSeen)
         downstreamPairEn <= chanDecode(chanSel);
   end

   // ----------------------------------------------------------------------
   // Combined interrupt output
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         link.devIrqOut <= 1'b0;
         link.devIrqOeN <= 1'b1;
      end
      else
      begin
         link.devIrqOut <= 1'b0;
         link.devIrqOeN <= ~(|irqFlags);
      end
   end

endmodule : i2cmx_mux_dev

`default_nettype wire

// >>> i2cmx_link_sva.sv
// Purpose: Checker on the link between controller and selector
// Assumes: One clock domain, clk_sys
// Notes: Instanced beside the link, no bind
`timescale 1ns/1ps
`default_nettype none

module i2cmx_link_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Link wires and drivers
   input wire logic scl,
   input wire logic sda,
   input wire logic hostSclOut,
   input wire logic hostSdaOut,
   input wire logic devSdaOut,
   input wire logic devSdaOeN,
   input wire logic devIrqOut,
   input wire logic devIrqOeN,
   // Selector side
   input wire logic chan0IrqInN,
   input wire logic chan1IrqInN,
   input wire logic chan2IrqInN,
   input wire logic chan3IrqInN,
   input wire logic [3:0] downstreamPairEn
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   logic allHigh;
   assign allHigh = chan0IrqInN & chan1IrqInN & chan2IrqInN & chan3IrqInN;

   a_one_chan: assert property ($onehot0(downstreamPairEn))
      else $error("more than one channel connected");
   a_switch_at_stop: assert property ($changed(downstreamPairEn) |-> scl && sda && $past(scl, 4))
      else $error("channel changed outside a stop");
   a_irq_assert: assert property ($fell(allHigh) |-> ##[1:5] !devIrqOeN)
      else $error("combined irq not driven");
   a_irq_release: assert property ($rose(allHigh) |-> ##[1:5] devIrqOeN)
      else $error("combined irq held after release");
   a_irq_idle: assert property (allHigh [*6] |=> devIrqOeN)
      else $error("combined irq without cause");
   a_open_drain: assert property (!hostSclOut && !hostSdaOut && !devSdaOut && !devIrqOut)
      else $error("open-drain line driven high");
   a_sda_scl_low: assert property ($changed(devSdaOeN) |-> !scl && !$past(scl, 2))
      else $error("device data moved with clock high");
   a_reset_idle: assert property ($rose(rstn) |-> downstreamPairEn == 4'h0 && devSdaOeN)
      else $error("not idle after reset");

   cover property (downstreamPairEn == 4'h8);
   cover property ($fell(devIrqOeN));
   cover property ($fell(devSdaOeN));
endmodule : i2cmx_link_sva

`default_nettype wire

// >>> i2c_channel_select_mux_ctrl_bench.sv
// Purpose: Bench joining controller and selector over the link
// Assumes: 10 MHz clk_sys, straps fixed
// Notes: Registers reached over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "i2cmx_consts.svh"

module i2c_channel_select_mux_ctrl_bench;
   localparam logic [2:0] STRAP = 3'h5;
   localparam logic [6:0] DEV = {`I2CMX_ADDR_UPPER, STRAP};
   logic clk_sys, rstn;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   logic [3:0] irqN, downstreamPairEn;
   int mismatches, check_count;

   i2cmx_link_if i2cmx_link_if_inst ();
   i2cmx_mux_dev i2cmx_mux_dev_inst (.clk_sys(clk_sys), .rstn(rstn),
      .link(i2cmx_link_if_inst.dev), .hwAddrPins(STRAP), .chan0IrqInN(irqN[0]),
      .chan1IrqInN(irqN[1]), .chan2IrqInN(irqN[2]), .chan3IrqInN(irqN[3]),
      .downstreamPairEn(downstreamPairEn));
   i2cmx_host_ctrl i2cmx_host_ctrl_inst (.clk_sys(clk_sys), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(i2cmx_link_if_inst.host));
   i2cmx_link_sva i2cmx_link_sva_inst (.clk_sys(clk_sys), .rstn(rstn),
      .scl(i2cmx_link_if_inst.scl), .sda(i2cmx_link_if_inst.sda),
      .hostSclOut(i2cmx_link_if_inst.hostSclOut), .hostSdaOut(i2cmx_link_if_inst.hostSdaOut),
      .devSdaOut(i2cmx_link_if_inst.devSdaOut), .devSdaOeN(i2cmx_link_if_inst.devSdaOeN),
      .devIrqOut(i2cmx_link_if_inst.devIrqOut), .devIrqOeN(i2cmx_link_if_inst.devIrqOeN),
      .chan0IrqInN(irqN[0]), .chan1IrqInN(irqN[1]), .chan2IrqInN(irqN[2]),
      .chan3IrqInN(irqN[3]), .downstreamPairEn(downstreamPairEn));

   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic limit(input int n, input int lim);
      if (n >= lim)
      begin
         mismatches++;
         $display("[FAIL] wait expected done seen timeout");
         finish_test();
      end
   endtask : limit

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 99; n++)
      begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      limit(n, 99);
      chk(`I2CMX_RESP_OKAY, bresp, "write resp");
      @(posedge clk_sys);
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 99; n++)
      begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      limit(n, 99);
      @(posedge clk_sys);
   endtask : axi_rd

   task automatic xfer(input logic [31:0] cmd, output logic [31:0] st);
      int n;
      logic [1:0] r;
      axi_wr(`I2CMX_REG_CMD, cmd);
      for (n = 0; n < 2000; n++)
      begin
         axi_rd(`I2CMX_REG_STATUS, st, r);
         if (st[0] === 1'b0) break;
      end
      limit(n, 2000);
      chk(`I2CMX_RESP_OKAY, r, "status resp");
   endtask : xfer

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic test_reset;
      logic [31:0] d;
      logic [1:0] r;
      chk(0, downstreamPairEn, "chan after reset");
      axi_rd(32'h0000_0010, d, r);
      chk(`I2CMX_RESP_SLVERR, r, "unmapped resp");
      $display("test_reset done");
   endtask : test_reset

   task automatic test_select;
      logic [7:0] tbl[7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0D, 8'hF3, 8'h00};
      logic [31:0] st;
      foreach (tbl[i])
      begin
         xfer({16'h0, tbl[i], 1'b0, DEV}, st);
         chk(0, st[1], "write ack");
         chk(tbl[i][2] ? 4'h1 << tbl[i][1:0] : 4'h0, downstreamPairEn, "chan");
         xfer({24'h0, 1'b1, DEV}, st);
         chk({4'h0, 1'b0, tbl[i][2:0]}, st[15:8], "readback");
      end
      $display("test_select done");
   endtask : test_select

   task automatic test_irq;
      logic [3:0] pat[4] = '{4'hE, 4'h5, 4'h0, 4'hF};
      logic [2:0] sel = 3'h0;
      logic [31:0] st;
      foreach (pat[i])
      begin
         irqN <= pat[i];
         repeat (6) @(posedge clk_sys);
         chk(pat[i] == 4'hF, i2cmx_link_if_inst.irqLine, "irq line");
         xfer({24'h0, 1'b1, DEV}, st);
         chk({4'(~pat[i]), 1'b0, sel}, st[15:8], "flags");
         chk(pat[i] != 4'hF, st[2], "irq status");
         if (pat[i] == 4'h5)
         begin
            sel = 3'h5;
            xfer({16'h0, 5'h00, sel, 1'b0, DEV}, st);
            chk(4'h2, downstreamPairEn, "flagged chan");
         end
      end
      $display("test_irq done");
   endtask : test_irq

   task automatic test_foreign;
      logic [31:0] st;
      xfer({16'h0, 8'h05, 1'b0, DEV}, st);
      xfer({16'h0, 8'h07, 1'b0, DEV ^ 7'h01}, st);
      chk(1, st[1], "foreign nack");
      chk(4'h2, downstreamPairEn, "chan kept");
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(0, downstreamPairEn, "chan after reset");
      $display("test_foreign done");
   endtask : test_foreign

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   initial
   begin
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, wdata, araddr} = 96'h0;
      irqN = 4'hF;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      test_reset();
      test_select();
      test_irq();
      test_foreign();
      finish_test();
   end
endmodule : i2c_channel_select_mux_ctrl_bench

`default_nettype wire
